// *** verilog/fault_seq_pkg.sv ***
/*
 * constants for the fault latch and suspend sequencer: strap level codes,
 * target code layout, blanking counts.
 * assumes a 50 MHz system clock; target codes are in 25 mV steps above 0 V.
 */
package fault_seq_pkg;
	localparam int unsigned SYS_CLK_HZ = 50000000;
	localparam int unsigned UV_BLANK_STEPS = 24;
	localparam logic [1:0] LVL_GND = 2'h0;
	localparam logic [1:0] LVL_MID = 2'h1;
	localparam logic [1:0] LVL_OPEN = 2'h2;
	localparam logic [1:0] LVL_SUPPLY = 2'h3;
	localparam int unsigned CODE_W = 7;
	// codes in 25 mV units: 0.675 V = 27, 1.075 V = 43
	localparam logic [6:0] LOWER_BANK_BASE = 7'h1B;
	localparam logic [6:0] UPPER_BANK_BASE = 7'h2B;
	localparam logic [6:0] ZERO_CODE = 7'h00;
	localparam logic [4:0] BLANK_CNT_RESET = 5'h00;
endpackage

// *** verilog/fault_latch_suspend_sequencer.sv ***
/*
 * fault latch, soft-shutdown ramp, no-fault test mode, suspend target decode
 * and alternating on-time trigger gating of a dual-phase step-down controller.
 * assumes comparator and pin inputs are asynchronous to sys_clk; step_tick
 * is a one-cycle pulse from the slew clock divider in this domain.
 */
// Function
// - undervoltage masked during target moves and 24 step clocks after arrival
// - over-temperature sets fault latch and ramps target toward zero
// - after faulted ramp reaches zero, low gates on, high gates off
// - latch clears only by power_down_n toggle, power loss or test mode entry; thermal waits cool
// - test mode ignores overvoltage, undervoltage, thermal faults; overlap disabled
// - entering test mode clears a set fault latch
// - suspend target is bank base plus 25 mV times strap index
// - on-time starts only with comparator low, valley ok, off-time expired
// - on-time triggers alternate between main and secondary phases
`timescale 1ns/1ns
module fault_latch_suspend_sequencer (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// host pins
	input wire logic power_down_n,
	input wire logic test_mode_level,
	input wire logic suspend_hi,
	input wire logic suspend_mid,
	input wire logic [1:0] suspend_code_lo,
	input wire logic [1:0] suspend_code_hi,
	input wire logic vcc_ok,
	// analog comparators and timers
	input wire logic over_temp,
	input wire logic temp_cooled,
	input wire logic over_voltage,
	input wire logic undervoltage_trip,
	input wire logic error_comp_low,
	input wire logic valley_ok_main,
	input wire logic valley_ok_sec,
	input wire logic min_off_done,
	input wire logic step_tick,
	input wire logic [6:0] normal_target,
	// outputs
	output logic [6:0] target_code,
	output logic fault_latched,
	output logic uv_masked,
	output logic test_mode,
	output logic overlap_enable,
	output logic low_side_gate_main,
	output logic low_side_gate_sec,
	output logic high_side_gate_main,
	output logic high_side_gate_sec,
	output logic on_trigger_main,
	output logic on_trigger_sec
);
	localparam int NI = 13;
	// two-flop synchronisers for all asynchronous inputs
	logic [NI-1:0] async_in, s1_reg, s2_reg;
	logic [1:0] lo_s1_reg, lo_s2_reg, hi_s1_reg, hi_s2_reg;
	assign async_in = {power_down_n, test_mode_level, suspend_hi, suspend_mid, vcc_ok,
		over_temp, temp_cooled, over_voltage, undervoltage_trip, error_comp_low,
		valley_ok_main, valley_ok_sec, min_off_done};
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s1_reg <= '0;
			s2_reg <= '0;
			lo_s1_reg <= 2'h0;
			lo_s2_reg <= 2'h0;
			hi_s1_reg <= 2'h0;
			hi_s2_reg <= 2'h0;
		end else begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			lo_s1_reg <= suspend_code_lo;
			lo_s2_reg <= lo_s1_reg;
			hi_s1_reg <= suspend_code_hi;
			hi_s2_reg <= hi_s1_reg;
		end
	end
	logic pdn_s, tm_s, shi_s, smid_s, vok_s, ot_s, cool_s, ov_s, uv_s, ec_s, vm_s, vs_s, mo_s;
	assign {pdn_s, tm_s, shi_s, smid_s, vok_s, ot_s, cool_s, ov_s, uv_s, ec_s, vm_s, vs_s,
		mo_s} = s2_reg;

	function automatic logic [6:0] bank_code(input logic [6:0] base, input logic [1:0] hi,
		input logic [1:0] lo);
		bank_code = base + {3'h0, hi, lo};
	endfunction

	logic [6:0] target_reg, target_next, goal;
	logic fault_reg, fault_next, pdn_d_reg, tm_d_reg, thermal_reg, thermal_next;
	logic [4:0] blank_reg, blank_next;
	logic phase_reg, phase_next, trig_m_reg, trig_m_next, trig_s_reg, trig_s_next;
	logic lo_g_reg, lo_g_next, hi_g_reg, hi_g_next, at_goal;

	always_comb begin
		if (fault_reg || !pdn_s)
			goal = fault_seq_pkg::ZERO_CODE;
		else if (shi_s)
			goal = bank_code(fault_seq_pkg::LOWER_BANK_BASE, hi_s2_reg, lo_s2_reg);
		else if (smid_s)
			goal = bank_code(fault_seq_pkg::UPPER_BANK_BASE, hi_s2_reg, lo_s2_reg);
		else
			goal = normal_target;
		at_goal = (target_reg == goal);
		target_next = target_reg;
		if (step_tick && !at_goal)
			target_next = (target_reg < goal) ? target_reg + 7'h01 : target_reg - 7'h01;
		blank_next = blank_reg;
		if (!at_goal)
			blank_next = 5'(fault_seq_pkg::UV_BLANK_STEPS);
		else if (step_tick && blank_reg != fault_seq_pkg::BLANK_CNT_RESET)
			blank_next = blank_reg - 5'h01;
		thermal_next = thermal_reg;
		fault_next = fault_reg;
		if (tm_s && !tm_d_reg) begin
			fault_next = 1'b0;
			thermal_next = 1'b0;
		end else if (!tm_s && (ot_s || ov_s || (uv_s && blank_reg == 5'h00 && at_goal))) begin
			fault_next = 1'b1;
			thermal_next = thermal_reg | ot_s;
		end else if (!vok_s || (pdn_s && !pdn_d_reg && (!thermal_reg || cool_s))) begin
			fault_next = 1'b0;
			thermal_next = 1'b0;
		end
		lo_g_next = fault_reg && target_reg == fault_seq_pkg::ZERO_CODE;
		hi_g_next = 1'b0;
		trig_m_next = 1'b0;
		trig_s_next = 1'b0;
		phase_next = phase_reg;
		if (!fault_reg && pdn_s && ec_s && mo_s && !trig_m_reg && !trig_s_reg) begin
			if (!phase_reg && vm_s) begin
				trig_m_next = 1'b1;
				phase_next = 1'b1;
			end else if (phase_reg && vs_s) begin
				trig_s_next = 1'b1;
				phase_next = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			target_reg <= fault_seq_pkg::ZERO_CODE;
			blank_reg <= 5'(fault_seq_pkg::UV_BLANK_STEPS);
			fault_reg <= 1'b0;
			thermal_reg <= 1'b0;
			pdn_d_reg <= 1'b0;
			tm_d_reg <= 1'b0;
			phase_reg <= 1'b0;
			trig_m_reg <= 1'b0;
			trig_s_reg <= 1'b0;
			lo_g_reg <= 1'b0;
			hi_g_reg <= 1'b0;
		end else begin
			target_reg <= target_next;
			blank_reg <= blank_next;
			fault_reg <= fault_next;
			thermal_reg <= thermal_next;
			pdn_d_reg <= pdn_s;
			tm_d_reg <= tm_s;
			phase_reg <= phase_next;
			trig_m_reg <= trig_m_next;
			trig_s_reg <= trig_s_next;
			lo_g_reg <= lo_g_next;
			hi_g_reg <= hi_g_next;
		end
	end

	// overlap is the inverse of test mode; registered copies so outputs come from flops
	logic tm_o_reg, uvm_reg, ovl_reg;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tm_o_reg <= 1'b0;
			ovl_reg <= 1'b1;
			uvm_reg <= 1'b1;
		end else begin
			tm_o_reg <= tm_s;
			ovl_reg <= !tm_s;
			uvm_reg <= !at_goal || blank_reg != 5'h00 || tm_s;
		end
	end
	assign target_code = target_reg;
	assign fault_latched = fault_reg;
	assign uv_masked = uvm_reg;
	assign test_mode = tm_o_reg;
	assign overlap_enable = ovl_reg;
	assign low_side_gate_main = lo_g_reg;
	assign low_side_gate_sec = lo_g_reg;
	assign high_side_gate_main = hi_g_reg;
	assign high_side_gate_sec = hi_g_reg;
	assign on_trigger_main = trig_m_reg;
	assign on_trigger_sec = trig_s_reg;

	property p_ot_fault;
		@(posedge sys_clk) disable iff (srst) (ot_s && !tm_s) |=> fault_reg;
	endproperty
	a_ot_fault: assert property (p_ot_fault) else $error("thermal fault not latched");
	property p_gates;
		@(posedge sys_clk) disable iff (srst)
		(fault_reg && target_reg == 7'h00) ##1 fault_reg |-> lo_g_reg && !hi_g_reg;
	endproperty
	a_gates: assert property (p_gates) else $error("safe gate state missing");
	property p_uv_blank;
		@(posedge sys_clk) disable iff (srst)
		!at_goal |=> blank_reg == 5'(fault_seq_pkg::UV_BLANK_STEPS);
	endproperty
	a_uv_blank: assert property (p_uv_blank) else $error("blank count not loaded");
	property p_tm_ignore;
		@(posedge sys_clk) disable iff (srst) (tm_s && !fault_reg) |=> !fault_reg;
	endproperty
	a_tm_ignore: assert property (p_tm_ignore) else $error("fault set in test mode");
	property p_tm_clear;
		@(posedge sys_clk) disable iff (srst) (tm_s && !tm_d_reg) |=> !fault_reg;
	endproperty
	a_tm_clear: assert property (p_tm_clear) else $error("test entry kept fault");
	property p_hold;
		@(posedge sys_clk) disable iff (srst)
		(fault_reg && vok_s && !tm_s && !(pdn_s && !pdn_d_reg)) |=> fault_reg;
	endproperty
	a_hold: assert property (p_hold) else $error("fault cleared without cause");
	property p_trig;
		@(posedge sys_clk) disable iff (srst)
		trig_m_reg |-> $past(ec_s) && $past(mo_s) && $past(vm_s);
	endproperty
	a_trig: assert property (p_trig) else $error("trigger without conditions");
	property p_alt;
		@(posedge sys_clk) disable iff (srst) trig_m_reg |=> !trig_m_reg [*3];
	endproperty
	a_alt: assert property (p_alt) else $error("main phase triggered twice");
endmodule

// *** testbench/host_pin_model.sv ***
/* host-side pin model: drives the shutdown pin and its test-level flag.
   assumes request levels come from the bench in the sys_clk domain. */
`timescale 1ns/1ns
module host_pin_model (
	// clock
	input wire logic sys_clk,
	// host requests
	input wire logic battery_ok,
	input wire logic enable_req,
	input wire logic test_req,
	// pins
	output logic power_down_n,
	output logic test_mode_level
);
	// enable held back until battery is up, else startup may fail
	// pins move on the rising edge by nonblocking update, clear of the bench's falling edge
	always @(posedge sys_clk) begin
		power_down_n <= enable_req & battery_ok;
		test_mode_level <= enable_req & test_req;
	end
endmodule

// *** testbench/tb.sv ***
/* self-checking bench for the fault latch and suspend sequencer.
   assumes the design's sync latency of 2 edges on asynchronous inputs. */
`timescale 1ns/1ns
module tb;
	logic sys_clk = 1'b0, srst = 1'b1, bat = 1'b0, en = 1'b1, tst = 1'b0;
	logic s_hi = 1'b0, s_mid = 1'b0, vcc = 1'b1, ot = 1'b0, cool = 1'b0, ov = 1'b0;
	logic uvt = 1'b0, ecl = 1'b0, vm = 1'b0, vs = 1'b0, mod = 1'b0, tick = 1'b0;
	logic [1:0] lo = 2'h0, hi = 2'h0;
	logic pd_n, tml, flt, uvm, tm, ovl, lm, ls, hm, hs, trm, trs;
	logic [6:0] tgt, goal, nt = 7'h00;
	logic [1:0] exp_q[$];
	int mismatches = 0, n_compared = 0, cyc = 0;
	always #10 sys_clk = ~sys_clk;
	host_pin_model host (.sys_clk(sys_clk), .battery_ok(bat), .enable_req(en),
		.test_req(tst), .power_down_n(pd_n), .test_mode_level(tml));
	fault_latch_suspend_sequencer uut (.sys_clk(sys_clk), .srst(srst), .power_down_n(pd_n),
		.test_mode_level(tml), .suspend_hi(s_hi), .suspend_mid(s_mid),
		.suspend_code_lo(lo), .suspend_code_hi(hi), .vcc_ok(vcc), .over_temp(ot),
		.temp_cooled(cool), .over_voltage(ov), .undervoltage_trip(uvt),
		.error_comp_low(ecl), .valley_ok_main(vm), .valley_ok_sec(vs),
		.min_off_done(mod), .step_tick(tick), .normal_target(nt), .target_code(tgt),
		.fault_latched(flt), .uv_masked(uvm), .test_mode(tm), .overlap_enable(ovl),
		.low_side_gate_main(lm), .low_side_gate_sec(ls), .high_side_gate_main(hm),
		.high_side_gate_sec(hs), .on_trigger_main(trm), .on_trigger_sec(trs));
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic ticks(input int n);
		repeat (n) begin
			@(negedge sys_clk) tick = 1'b1;
			@(negedge sys_clk) tick = 1'b0;
		end
	endtask
	// an unexpected trigger pops nothing and compares against FF
	// looked at on the falling edge, where the registered pulses have settled
	always @(negedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			close_out();
		end
		if (!srst && (trm || trs)) begin
			if (exp_q.size() == 0) chk({6'h00, trm, trs}, 8'hFF);
			else chk({6'h00, trm, trs}, {6'h00, exp_q.pop_front()});
		end
	end
	initial begin
		void'($urandom(32'h4E03));
		wt(20);
		srst = 1'b0;
		chk({tgt, uvm}, 8'h01);
		chk({flt, tm, ovl}, 8'h01);
		bat = 1'b1;
		for (int b = 0; b < 3; b++) begin
			s_hi = (b == 0);
			s_mid = (b == 1);
			lo = 2'($urandom);
			hi = 2'($urandom);
			// third pass leaves suspend for the normal target, kept within 47 codes of the last
			nt = 7'h3B + 7'($urandom % 32);
			goal = (b == 2) ? nt : (b == 1 ? 7'h2B : 7'h1B) + {3'h0, hi, 2'h0} + {5'h00, lo};
			wt(4);
			ticks(2);
			chk({7'h00, uvm}, 8'h01);
			ticks(70);
			chk({1'b0, tgt}, {1'b0, goal});
			chk({7'h00, uvm}, 8'h00);
		end
		ecl = 1'b1;
		vm = 1'b1;
		vs = 1'b1;
		wt(10);
		for (int i = 0; i < 4; i++) exp_q.push_back(i % 2 == 0 ? 2'h2 : 2'h1);
		mod = 1'b1;
		wt(8);
		ecl = 1'b0;
		mod = 1'b0;
		wt(6);
		chk(8'(exp_q.size()), 8'h00);
		ot = 1'b1;
		wt(4);
		chk({7'h00, flt}, 8'h01);
		ticks(96);
		wt(2);
		chk({tgt, lm}, 8'h01);
		chk({lm, ls, hm, hs}, 8'h0C);
		en = 1'b0;
		wt(4);
		en = 1'b1;
		wt(5);
		chk({7'h00, flt}, 8'h01);
		ot = 1'b0;
		cool = 1'b1;
		en = 1'b0;
		wt(4);
		en = 1'b1;
		wt(5);
		chk({7'h00, flt}, 8'h00);
		ov = 1'b1;
		wt(5);
		chk({7'h00, flt}, 8'h01);
		ov = 1'b0;
		vcc = 1'b0;
		wt(5);
		vcc = 1'b1;
		chk({7'h00, flt}, 8'h00);
		ot = 1'b1;
		wt(5);
		tst = 1'b1;
		wt(5);
		chk({flt, tm, ovl}, 8'h02);
		ov = 1'b1;
		uvt = 1'b1;
		wt(5);
		chk({7'h00, flt}, 8'h00);
		close_out();
	end
endmodule
